// File: rtl/twv_top.v
// Timer waveform generation and compare-output control with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "twv_consts.vh"

module twv_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output wire        compare_out_a,
    output wire        compare_out_a_override,
    output wire        compare_out_b,
    output wire        compare_out_b_override
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function [1:0] wave_class_of;
        input [2:0] mode;
        begin
            case (mode)
                `TWV_WM_NORMAL,
                `TWV_WM_CLEAR_MATCH: wave_class_of = `TWV_CLS_NONPWM;
                `TWV_WM_FAST_FF,
                `TWV_WM_FAST_CA:  wave_class_of = `TWV_CLS_FAST;
                `TWV_WM_PHASE_FF,
                `TWV_WM_PHASE_CA: wave_class_of = `TWV_CLS_PHASE;
                default:          wave_class_of = `TWV_CLS_RSVD;
            endcase
        end
    endfunction

    function addr_is;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_is = (addr == target);
        end
    endfunction

    function is_pwm;
        input [1:0] cls;
        begin
            is_pwm = (cls == `TWV_CLS_FAST) || (cls == `TWV_CLS_PHASE);
        end
    endfunction

    // Registers sit in the lowest page only; anything above is unmapped
    function in_map;
        input [23:0] page;
        begin
            in_map = (page == 24'h000000);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    reg  [7:0] ctrl_ff;
    reg        high_bit_ff;
    reg        run_ff;
    reg  [7:0] cmp_a_buf_ff;
    reg  [7:0] cmp_b_buf_ff;
    reg  [7:0] cmp_a_ff;
    reg  [7:0] cmp_b_ff;
    reg  [7:0] count_ff;
    reg        up_ff;
    reg        ovf_ff;
    reg        dp_write_ff;
    reg  [7:0] dp_addr_ff;

    reg  [7:0] nxt_count;
    reg        nxt_up;
    reg        ovf_ev;
    reg  [7:0] nxt_cmp_a;
    reg  [7:0] nxt_cmp_b;
    reg  [31:0] nxt_hrdata;

    wire [2:0] wave_mode_field;
    wire [1:0] wave_class;
    wire       top_is_cmp_a;
    wire [7:0] top_value;
    wire       at_top;
    wire       at_bottom;
    wire       phase_top_ev;
    wire       fast_bottom_ev;
    wire       load_ev;
    wire       match_a;
    wire       match_b;
    wire       addr_phase;
    wire       wr_ctrl;
    wire       wr_ctrl2;
    wire       wr_cmp_a;
    wire       wr_cmp_b;
    wire       wr_count;
    wire       wr_status;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    assign wave_mode_field = {high_bit_ff, ctrl_ff[`TWV_CTRL_WM_HI:`TWV_CTRL_WM_LO]};
    assign wave_class      = wave_class_of(wave_mode_field);

    assign top_is_cmp_a = (wave_mode_field == `TWV_WM_CLEAR_MATCH) ||
                          (wave_mode_field == `TWV_WM_PHASE_CA) ||
                          (wave_mode_field == `TWV_WM_FAST_CA);
    assign top_value    = top_is_cmp_a ? cmp_a_ff : `TWV_MAX;

    assign at_top    = (count_ff == top_value);
    assign at_bottom = (count_ff == `TWV_BOTTOM);

    assign phase_top_ev   = run_ff && at_top && up_ff && (wave_class == `TWV_CLS_PHASE);
    assign fast_bottom_ev = run_ff && at_bottom && (wave_class == `TWV_CLS_FAST);

    // Fast PWM loads on the wrap so the new value is live from bottom
    assign load_ev = run_ff && at_top &&
                     ((wave_class == `TWV_CLS_FAST) ||
                      ((wave_class == `TWV_CLS_PHASE) && up_ff));

    assign match_a = run_ff && (count_ff == cmp_a_ff);
    assign match_b = run_ff && (count_ff == cmp_b_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Counter sequence

    always @* begin
        nxt_count = count_ff;
        nxt_up    = up_ff;
        ovf_ev    = 1'b0;
        if (run_ff) begin
            if (wave_class == `TWV_CLS_PHASE) begin
                if (up_ff) begin
                    if (at_top) begin
                        nxt_up = 1'b0;
                        if (!at_bottom)
                            nxt_count = count_ff - 8'h01;
                    end else begin
                        nxt_count = count_ff + 8'h01;
                    end
                end else if (at_bottom) begin
                    nxt_up = 1'b1;
                    ovf_ev = 1'b1;
                    if (!at_top)
                        nxt_count = count_ff + 8'h01;
                end else begin
                    nxt_count = count_ff - 8'h01;
                end
            end else begin
                // Normal, clear-on-match, fast PWM and reserved modes count up
                nxt_up = 1'b1;
                if (at_top)
                    nxt_count = `TWV_BOTTOM;
                else
                    nxt_count = count_ff + 8'h01;
                if (wave_mode_field == `TWV_WM_FAST_CA)
                    ovf_ev = at_top;
                else
                    ovf_ev = (count_ff == `TWV_MAX);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare registers: immediate outside PWM, buffered inside it

    always @* begin
        nxt_cmp_a = cmp_a_ff;
        nxt_cmp_b = cmp_b_ff;
        if (is_pwm(wave_class)) begin
            if (load_ev) begin
                nxt_cmp_a = cmp_a_buf_ff;
                nxt_cmp_b = cmp_b_buf_ff;
            end
        end else begin
            // Immediate update also covers a write in this very data phase
            nxt_cmp_a = wr_cmp_a ? hwdata[7:0] : cmp_a_buf_ff;
            nxt_cmp_b = wr_cmp_b ? hwdata[7:0] : cmp_b_buf_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel && hready && htrans[1];

    assign wr_ctrl   = dp_write_ff && addr_is(dp_addr_ff, `TWV_ADDR_CTRL);
    assign wr_ctrl2  = dp_write_ff && addr_is(dp_addr_ff, `TWV_ADDR_CTRL2);
    assign wr_cmp_a  = dp_write_ff && addr_is(dp_addr_ff, `TWV_ADDR_CMP_A);
    assign wr_cmp_b  = dp_write_ff && addr_is(dp_addr_ff, `TWV_ADDR_CMP_B);
    assign wr_count  = dp_write_ff && addr_is(dp_addr_ff, `TWV_ADDR_COUNT);
    assign wr_status = dp_write_ff && addr_is(dp_addr_ff, `TWV_ADDR_STATUS);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_ff <= 1'b0;
            dp_addr_ff  <= 8'h00;
        end else begin
            dp_write_ff <= addr_phase && hwrite && in_map(haddr[31:8]);
            dp_addr_ff  <= haddr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Read data is sampled in the address phase and held for the data phase
    always @* begin
        nxt_hrdata = 32'h00000000;
        if (!in_map(haddr[31:8]))
            nxt_hrdata = 32'h00000000;
        else if (addr_is(haddr[7:0], `TWV_ADDR_CTRL))
            nxt_hrdata = {24'h000000, ctrl_ff & `TWV_CTRL_WMASK};
        else if (addr_is(haddr[7:0], `TWV_ADDR_CTRL2))
            nxt_hrdata = {28'h0000000, high_bit_ff, 2'h0, run_ff};
        else if (addr_is(haddr[7:0], `TWV_ADDR_CMP_A))
            nxt_hrdata = {24'h000000, cmp_a_buf_ff};
        else if (addr_is(haddr[7:0], `TWV_ADDR_CMP_B))
            nxt_hrdata = {24'h000000, cmp_b_buf_ff};
        else if (addr_is(haddr[7:0], `TWV_ADDR_COUNT))
            nxt_hrdata = {24'h000000, count_ff};
        else if (addr_is(haddr[7:0], `TWV_ADDR_STATUS))
            nxt_hrdata = {30'h00000000, up_ff, ovf_ff};
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_phase && !hwrite)
            hrdata <= nxt_hrdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register and compare buffer state

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff      <= `TWV_CTRL_RESET;
            high_bit_ff  <= 1'b0;
            run_ff       <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl_ff <= hwdata[7:0] & `TWV_CTRL_WMASK;
            if (wr_ctrl2) begin
                high_bit_ff <= hwdata[`TWV_CTRL2_HIGH_BIT];
                run_ff      <= hwdata[`TWV_CTRL2_RUN];
            end
        end
    end

    // Buffers hold what software wrote; reads return them, not the live value
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_a_buf_ff <= 8'h00;
            cmp_b_buf_ff <= 8'h00;
        end else begin
            if (wr_cmp_a)
                cmp_a_buf_ff <= hwdata[7:0];
            if (wr_cmp_b)
                cmp_b_buf_ff <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and live compare values

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_a_ff <= 8'h00;
            cmp_b_ff <= 8'h00;
            count_ff <= 8'h00;
            up_ff    <= 1'b1;
        end else begin
            cmp_a_ff <= nxt_cmp_a;
            cmp_b_ff <= nxt_cmp_b;
            // Software write to the counter wins over counting
            if (wr_count)
                count_ff <= hwdata[7:0];
            else
                count_ff <= nxt_count;
            up_ff <= nxt_up;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag

    // Set wins over a write-one clear in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ovf_ff <= 1'b0;
        else if (ovf_ev)
            ovf_ff <= 1'b1;
        else if (wr_status && hwdata[`TWV_STAT_OVF])
            ovf_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output channels

    twv_chan u_chan_a (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .out_mode     (ctrl_ff[`TWV_CTRL_MODE_A_HI:`TWV_CTRL_MODE_A_LO]),
        .wave_class   (wave_class),
        .toggle_ok    (high_bit_ff),
        .match        (match_a),
        .eq_top       (cmp_a_ff == top_value),
        .bottom_ev    (fast_bottom_ev),
        .top_ev       (phase_top_ev),
        .count_up     (up_ff),
        .wave_out_ff  (compare_out_a),
        .pin_override (compare_out_a_override)
    );

    twv_chan u_chan_b (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .out_mode     (ctrl_ff[`TWV_CTRL_MODE_B_HI:`TWV_CTRL_MODE_B_LO]),
        .wave_class   (wave_class),
        .toggle_ok    (1'b0),
        .match        (match_b),
        .eq_top       (cmp_b_ff == top_value),
        .bottom_ev    (fast_bottom_ev),
        .top_ev       (phase_top_ev),
        .count_up     (up_ff),
        .wave_out_ff  (compare_out_b),
        .pin_override (compare_out_b_override)
    );

endmodule // twv_top

`default_nettype wire

// File: rtl/twv_consts.vh
// Constants for the timer waveform and compare-output control block
//
// Overview of operation
// - Nonzero output-mode field hands pin to channel, except in reserved waveform modes 4 and 6 and PWM code 1 (channel B, or A without high bit)
// - Non-PWM codes: disconnect, toggle, clear, set on match
// - Fast PWM code 2 non-inverting, 3 inverting
// - PWM channel A code 1 needs high bit
// - PWM channel B code 1 is reserved
// - Phase PWM codes act by counting direction
// - Fast PWM compare equal top: only bottom action
// - Phase PWM compare equal top: action at top
// - Control bits 3, 2 read zero, ignore writes
// - Waveform mode is high bit plus low bits
// - Normal top 0xFF, clear-on-match top compare A
// - Phase PWM loads at top, flags at bottom
// - Fast PWM top, load at bottom, flag points
// - PWM overflow flag: phase PWM at bottom reversal, fast PWM at top
`ifndef TWV_CONSTS_VH
`define TWV_CONSTS_VH

// Byte addresses of the word registers
`define TWV_ADDR_CTRL       8'hB0
`define TWV_ADDR_CTRL2      8'hB4
`define TWV_ADDR_CMP_A      8'hB8
`define TWV_ADDR_CMP_B      8'hBC
`define TWV_ADDR_COUNT      8'hC0
`define TWV_ADDR_STATUS     8'hC4

// Control register fields and write mask
`define TWV_CTRL_MODE_A_HI  7
`define TWV_CTRL_MODE_A_LO  6
`define TWV_CTRL_MODE_B_HI  5
`define TWV_CTRL_MODE_B_LO  4
`define TWV_CTRL_WM_HI      1
`define TWV_CTRL_WM_LO      0
`define TWV_CTRL_WMASK      8'hF3
`define TWV_CTRL_RESET      8'h00

// Second control register fields
`define TWV_CTRL2_HIGH_BIT  3
`define TWV_CTRL2_RUN       0

// Status register fields
`define TWV_STAT_OVF        0
`define TWV_STAT_UP         1

// Counter landmarks
`define TWV_MAX             8'hFF
`define TWV_BOTTOM          8'h00

// Waveform modes
`define TWV_WM_NORMAL       3'h0
`define TWV_WM_PHASE_FF     3'h1
`define TWV_WM_CLEAR_MATCH  3'h2
`define TWV_WM_FAST_FF      3'h3
`define TWV_WM_RSVD4        3'h4
`define TWV_WM_PHASE_CA     3'h5
`define TWV_WM_RSVD6        3'h6
`define TWV_WM_FAST_CA      3'h7

// Waveform classes seen by the channels
`define TWV_CLS_NONPWM      2'h0
`define TWV_CLS_FAST        2'h1
`define TWV_CLS_PHASE       2'h2
`define TWV_CLS_RSVD        2'h3

`endif

// File: rtl/twv_chan.v
// One compare-output channel: waveform flip-flop and pin override
`timescale 1ns/1ps
`default_nettype none
`include "twv_consts.vh"

module twv_chan (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire [1:0] out_mode,
    input  wire [1:0] wave_class,
    input  wire       toggle_ok,
    input  wire       match,
    input  wire       eq_top,
    input  wire       bottom_ev,
    input  wire       top_ev,
    input  wire       count_up,
    output reg        wave_out_ff,
    output wire       pin_override
);

    reg nxt_wave_out;

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        nxt_wave_out = wave_out_ff;
        case (wave_class)
            `TWV_CLS_NONPWM: begin
                if (match) begin
                    case (out_mode)
                        2'h1:    nxt_wave_out = ~wave_out_ff;
                        2'h2:    nxt_wave_out = 1'b0;
                        2'h3:    nxt_wave_out = 1'b1;
                        default: nxt_wave_out = wave_out_ff;
                    endcase
                end
            end
            `TWV_CLS_FAST: begin
                if (out_mode[1]) begin
                    if (bottom_ev)
                        nxt_wave_out = ~out_mode[0];
                    // Match beats bottom so a zero compare still clears (code 2) or sets (code 3)
                    if (match && !eq_top)
                        nxt_wave_out = out_mode[0];
                end else if (out_mode[0] && toggle_ok && match) begin
                    nxt_wave_out = ~wave_out_ff;
                end
            end
            `TWV_CLS_PHASE: begin
                if (out_mode[1]) begin
                    if (match && !eq_top)
                        nxt_wave_out = count_up ? out_mode[0] : ~out_mode[0];
                    else if (top_ev && eq_top)
                        nxt_wave_out = out_mode[0];
                end else if (out_mode[0] && toggle_ok && match) begin
                    nxt_wave_out = ~wave_out_ff;
                end
            end
            default: nxt_wave_out = wave_out_ff;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wave_out_ff <= 1'b0;
        else
            wave_out_ff <= nxt_wave_out;
    end

    // Code 1 under PWM only drives when toggling is allowed
    assign pin_override = (out_mode != 2'h0) &&
                          (wave_class != `TWV_CLS_RSVD) &&
                          !(out_mode == 2'h1 && !toggle_ok &&
                            wave_class != `TWV_CLS_NONPWM);

endmodule // twv_chan

`default_nettype wire

// File: dv/twv_top_asserts.sv
// Concurrent checks on the ports of the timer waveform output control block
`timescale 1ns/1ps
`default_nettype none
module twv_top_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        compare_out_a,
    input wire logic        compare_out_a_override,
    input wire logic        compare_out_b,
    input wire logic        compare_out_b_override
);
    logic       wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [7:0] ctrl_ff;
    logic       high_ff;
    logic [2:0] mode;
    logic       rsvd;
    logic       exp_ovr_a;
    logic       exp_ovr_b;

    // Shadow of the control bits, updated at the end of each write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            ctrl_ff    <= 8'h00;
            high_ff    <= 1'b0;
        end else begin
            wr_pend_ff <= hsel && hready && htrans[1] && hwrite && haddr[31:8] == 24'h0;
            wr_addr_ff <= haddr[7:0];
            if (wr_pend_ff && wr_addr_ff == 8'hB0) begin
                ctrl_ff <= hwdata[7:0] & 8'hF3;
            end
            if (wr_pend_ff && wr_addr_ff == 8'hB4) begin
                high_ff <= hwdata[3];
            end
        end
    end

    assign mode      = {high_ff, ctrl_ff[1:0]};
    assign rsvd      = mode[2] && !mode[0];
    assign exp_ovr_a = ctrl_ff[7:6] != 2'h0 && !rsvd && !(ctrl_ff[7:6] == 2'h1 && mode == 3'h1)
                       && !(ctrl_ff[7:6] == 2'h1 && mode == 3'h3);
    assign exp_ovr_b = ctrl_ff[5:4] != 2'h0 && !rsvd && !(ctrl_ff[5:4] == 2'h1 && mode[0]);

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence rd_req(logic [7:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr == {24'h0, a};
    endsequence

    a_bus_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_ctrl_read_back: assert property (rd_req(8'hB0) ##0 !wr_pend_ff |=> hrdata == {24'h0, ctrl_ff})
        else $error("control read differs from written bits");
    a_unmapped_zero: assert property (rd_req(8'hD0) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_ovr_a_map: assert property (compare_out_a_override == exp_ovr_a)
        else $error("channel a pin ownership wrong");
    a_ovr_b_map: assert property (compare_out_b_override == exp_ovr_b)
        else $error("channel b pin ownership wrong");
    a_hold_a_idle: assert property (!$past(compare_out_a_override) |-> $stable(compare_out_a))
        else $error("channel a waveform moved while disconnected");
    a_hold_b_idle: assert property (!$past(compare_out_b_override) |-> $stable(compare_out_b))
        else $error("channel b waveform moved while disconnected");
    a_reset_clean: assert property ($rose(hresetn) |-> !compare_out_a && !compare_out_b
        && !compare_out_a_override && !compare_out_b_override && hrdata == 32'h0)
        else $error("outputs not idle after reset");
    a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
endmodule // twv_top_asserts

bind twv_top twv_top_asserts i_twv_top_asserts (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .compare_out_a(compare_out_a),
    .compare_out_a_override(compare_out_a_override), .compare_out_b(compare_out_b),
    .compare_out_b_override(compare_out_b_override)
);
`default_nettype wire

// File: dv/twv_pin_load.sv
// External load on the two compare pins: resolves pin levels, counts high cycles
`timescale 1ns/1ps
`default_nettype none
module twv_pin_load (
    input  wire logic       hclk,
    input  wire logic       clr,
    input  wire logic       dir_out,
    input  wire logic       port_a,
    input  wire logic       port_b,
    input  wire logic       cmp_a,
    input  wire logic       ovr_a,
    input  wire logic       cmp_b,
    input  wire logic       ovr_b,
    output var  logic [9:0] high_a,
    output var  logic [9:0] high_b
);
    logic pin_a;
    logic pin_b;

    // Undriven pin settles at the pull-up, never at a stale level
    assign pin_a = dir_out ? (ovr_a ? cmp_a : port_a) : 1'b1;
    assign pin_b = dir_out ? (ovr_b ? cmp_b : port_b) : 1'b1;

    always @(posedge hclk) begin
        if (clr) begin
            high_a <= 10'h000;
            high_b <= 10'h000;
        end else begin
            high_a <= high_a + {9'h000, pin_a};
            high_b <= high_b + {9'h000, pin_b};
        end
    end
endmodule // twv_pin_load
`default_nettype wire

// File: dv/twv_top_tb.sv
// Self-checking testbench for the timer waveform output control block
`timescale 1ns/1ps
`default_nettype none
module twv_top_tb;
    typedef struct packed {
        logic [7:0] c;
        logic [7:0] c2;
        logic [7:0] ca;
        logic [7:0] cb;
        logic [9:0] w;
        logic [9:0] ea;
        logic [9:0] eb;
        logic       f;
    } twv_row_t;

    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        cmp_a;
    logic        ovr_a;
    logic        cmp_b;
    logic        ovr_b;
    logic        clr;
    logic [9:0]  high_a;
    logic [9:0]  high_b;
    logic [31:0] q;
    twv_row_t    r;
    int          mismatches = 0;
    int          n_compared = 0;
    logic [1:0]  codes [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    // Disconnected pins show port levels a=1, b=0
    // Last row uses reserved mode 4 only to pin down the fallback
    twv_row_t    rows [9] = '{
        '{8'h40, 8'h01, 8'h10, 8'h00, 10'h200, 10'h100, 10'h000, 1'b1},
        '{8'h72, 8'h01, 8'h0F, 8'h08, 10'h020, 10'h010, 10'h020, 1'b0},
        '{8'hB1, 8'h01, 8'h80, 8'h40, 10'h1FE, 10'h100, 10'h17E, 1'b1},
        '{8'hE1, 8'h01, 8'hFF, 8'h80, 10'h1FE, 10'h1FE, 10'h100, 1'b1},
        '{8'hB3, 8'h01, 8'h80, 8'hFF, 10'h100, 10'h080, 10'h000, 1'b1},
        '{8'h63, 8'h09, 8'h7F, 8'h20, 10'h100, 10'h080, 10'h040, 1'b1},
        '{8'h31, 8'h09, 8'h7F, 8'h20, 10'h0FE, 10'h0FE, 10'h0BE, 1'b1},
        '{8'h13, 8'h01, 8'h80, 8'h80, 10'h100, 10'h100, 10'h000, 1'b1},
        '{8'hF0, 8'h09, 8'h10, 8'h10, 10'h100, 10'h100, 10'h000, 1'b1}};

    always #25 hclk = ~hclk;

    twv_top i_twv_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .compare_out_a(cmp_a),
        .compare_out_a_override(ovr_a), .compare_out_b(cmp_b), .compare_out_b_override(ovr_b));

    twv_pin_load i_twv_pin_load (.hclk(hclk), .clr(clr), .dir_out(1'b1), .port_a(1'b1),
        .port_b(1'b0), .cmp_a(cmp_a), .ovr_a(ovr_a), .cmp_b(cmp_b), .ovr_b(ovr_b),
        .high_a(high_a), .high_b(high_b));

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Address phase held until hready, then data phase until hready again
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, {24'h0, d});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk($sformatf("register %h", a), exp, q);
    endtask

    initial begin
        #1000000;
        $display("watchdog expired");
        mismatches++;
        stop_test();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        clr = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(8'hB0, 32'h0);
        chk("pin ownership", 32'h0, {30'h0, ovr_a, ovr_b});
        wr(8'hB0, 8'hFF);
        rd_chk(8'hB0, 32'hF3);
        wr(8'hD0, 8'hFF);
        rd_chk(8'hD0, 32'h0);
        wr(8'hB0, 8'h00);
        wr(8'hB8, 8'h20);
        wr(8'hBC, 8'h20);
        wr(8'hB4, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(8'hB0, {codes[i], codes[i], 4'h0});
            wr(8'hC0, 8'h1C);
            repeat (12) @(posedge hclk);
            chk("match pins", {30'h0, {2{~i[0]}}}, {30'h0, cmp_a, cmp_b});
        end
        for (int i = 0; i < 9; i++) begin
            r = rows[i];
            wr(8'hB4, 8'h00);
            wr(8'hB0, 8'h00);
            wr(8'hB8, r.ca);
            wr(8'hBC, r.cb);
            wr(8'hC0, 8'h00);
            wr(8'hB0, r.c);
            wr(8'hB4, r.c2);
            repeat (2 * r.w) @(posedge hclk);
            wr(8'hC4, 8'h01);
            @(posedge hclk) clr <= 1'b1;
            @(posedge hclk) clr <= 1'b0;
            repeat (r.w) @(posedge hclk);
            #1;
            chk("high cycles", {12'h0, r.ea, r.eb}, {12'h0, high_a, high_b});
            bus(8'hC4, 1'b0, 32'h0);
            chk("overflow flag", {31'h0, r.f}, {31'h0, q[0]});
        end
        wr(8'hB0, 8'hA0);
        @(posedge hclk) hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("reset pins", 32'h0, {28'h0, cmp_a, ovr_a, cmp_b, ovr_b});
        rd_chk(8'hB0, 32'h0);
        stop_test();
    end
endmodule // twv_top_tb
`default_nettype wire
